// ---- pdm_hist.sv ----
// Fifteen-minute loss interval history
`timescale 1ns/1ns
`default_nettype none
module pdm_hist #(
  parameter int unsigned INTV_SECS = pdm_pkg::INTV_SECS
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  tick,
  input  wire logic                  alarm_sec,
  input  wire logic                  lost_stb,
  input  wire logic [15:0]           lost_add,
  input  wire logic [6:0]            rd_idx,
  output pdm_pkg::pdm_hist_type      cur_q,
  output pdm_pkg::pdm_hist_type      rd_q,
  output logic [6:0]                 wr_ptr_q
);
  import pdm_pkg::*;

  pdm_hist_type mem [HIST_DEPTH];  // Completed intervals
  logic [9:0]   sec_q;             // Seconds into interval
  logic         wrap;

  assign wrap = tick && (sec_q >= 10'(INTV_SECS - 1));

  // Running counts of the open interval
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_q <= '0;
      sec_q <= 10'h0;
    end else begin
      if (wrap) begin
        sec_q      <= 10'h0;
        cur_q.lost <= lost_stb ? 32'(lost_add) : 32'h0;  // [RULE19]
        cur_q.alarm_secs <= 16'h0;
      end else begin
        if (tick) sec_q <= sec_q + 10'h1;
        if (lost_stb) cur_q.lost <= cur_q.lost + 32'(lost_add);  // [RULE19]
        if (tick && alarm_sec) cur_q.alarm_secs <= cur_q.alarm_secs + 16'h1;
      end
    end
  end

  // Closed interval goes to the ring; alarm of the last second counts too
  always_ff @(posedge clk) begin
    if (wrap) begin
      mem[wr_ptr_q].lost       <= cur_q.lost;  // [RULE18]
      mem[wr_ptr_q].alarm_secs <= cur_q.alarm_secs + 16'(alarm_sec);
    end
  end

  // Ring pointer wraps after the last of the day
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wr_ptr_q <= 7'h0;
    else if (wrap) wr_ptr_q <= (wr_ptr_q >= 7'(HIST_DEPTH - 1)) ? 7'h0 : wr_ptr_q + 7'h1;
  end

  // Registered read; indices past the last entry read as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rd_q <= '0;
    else if (rd_idx < 7'(HIST_DEPTH)) rd_q <= mem[rd_idx];
    else rd_q <= '0;
  end
endmodule
`default_nettype wire

// ---- pdm_monitor.sv ----
// Per-pseudowire loss state, alarm, second counters and TDM fill
`timescale 1ns/1ns
`default_nettype none
module pdm_monitor #(
  parameter int unsigned TICK_CYC  = pdm_pkg::TICK_CYC,
  parameter int unsigned LOSS_CYC  = pdm_pkg::LOSS_CYC,
  parameter int unsigned CLR_CYC   = pdm_pkg::CLR_CYC,
  parameter int unsigned INTV_SECS = pdm_pkg::INTV_SECS
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire pdm_pkg::pdm_cfg_type  cfg,
  input  wire logic                  fill_wr,
  input  wire logic [7:0]            fill_val,
  input  wire logic                  rx_valid,
  input  wire logic                  rx_is_pw,
  input  wire logic [15:0]           rx_seq,
  input  wire pdm_pkg::pdm_play_type play,
  input  wire logic [6:0]            hist_idx,
  output logic                       rx_accept_q,
  output logic                       rx_drop_q,
  output logic                       tx_rbit_q,
  output logic                       loss_state_q,
  output logic                       loss_alarm_q,
  output logic                       unavail_q,
  output logic                       tdm_valid_q,
  output logic [7:0]                 tdm_data_q,
  output logic                       tdm_dl_q,
  output logic [7:0]                 fill_q,
  output pdm_pkg::pdm_stat_type      stat_q,
  output pdm_pkg::pdm_hist_type      cur_intv_q,
  output pdm_pkg::pdm_hist_type      hist_q,
  output logic [6:0]                 hist_ptr_q
);
  import pdm_pkg::*;

  pdm_state_type st_q;         // Loss state machine
  logic          tick;         // One-second pulse
  logic          have_seq_q;   // First packet seen
  logic [15:0]   exp_q;        // Next expected sequence
  logic [15:0]   gap;          // Forward distance of arrival
  logic          is_pw;        // Pseudowire packet offered
  logic          late;         // Arrived behind expected
  logic          lost_stb;     // Gap found this cycle
  logic [15:0]   win_tot_q;    // Packets due in window
  logic [15:0]   win_lost_q;   // Packets lost in window
  logic [7:0]    win_sec_q;    // Seconds into window
  logic [22:0]   lost_x;       // Lost scaled by 100
  logic [22:0]   pct_x;        // Total scaled by percentage
  logic          enter;        // Condition to enter loss
  logic          leave;        // Condition to leave loss
  logic          err;          // One error defect now
  logic          pkt_bad_q;    // Current packet had filler
  logic [7:0]    good_q;       // Clean packets in a row
  logic [31:0]   loss_cyc_q;   // Cycles spent in loss
  logic [31:0]   quiet_q;      // Cycles since last defect
  logic [15:0]   sec_err_q;    // Defects this second
  logic          sec_alarm_q;  // Loss state seen this second
  logic          sec_ses;      // Closing second is severe
  logic [3:0]    ses_run_q;    // Severe seconds in a row
  logic [3:0]    ok_run_q;     // Clean seconds in a row
  logic          in_loss;

  // Saturating sixteen-bit add
  function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[16] ? 16'hffff : s[15:0];
  endfunction

  pdm_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .clk    (clk),
    .rst_n  (rst_n),
    .tick_q (tick)
  );

  // Loss statistics see only pseudowire traffic
  pdm_hist #(
    .INTV_SECS (INTV_SECS)
  ) u_hist (
    .clk       (clk),
    .rst_n     (rst_n),
    .tick      (tick),
    .alarm_sec (sec_alarm_q | in_loss),
    .lost_stb  (lost_stb),
    .lost_add  (gap),
    .rd_idx    (hist_idx),
    .cur_q     (cur_intv_q),
    .rd_q      (hist_q),
    .wr_ptr_q  (hist_ptr_q)
  );

  // Sequence checking; stray packets never reach it
  assign is_pw    = rx_valid && rx_is_pw;                            // [RULE20]
  assign gap      = rx_seq - exp_q;
  assign late     = have_seq_q && gap[15];                           // [RULE14]
  assign lost_stb = is_pw && have_seq_q && !gap[15] && (gap != 16'h0);
  assign in_loss  = (st_q == ST_LOSS) || (st_q == ST_ALARM);

  // Percentage test over the window, plus the missing run
  assign lost_x = 23'(win_lost_q) * 23'd100;
  assign pct_x  = 23'(cfg.loss_pct) * 23'(win_tot_q);
  assign enter  = ((win_tot_q != 16'h0) && (lost_x > pct_x))
               || (lost_stb && (cfg.miss_run != 8'h0) && (gap >= 16'(cfg.miss_run)));  // [RULE1]

  // Clean run reaches configured count or a full buffer
  assign leave = ((cfg.good_run != 8'h0) && (good_q >= cfg.good_run))
              || ((cfg.jb_pkts != 8'h0) && (good_q >= cfg.jb_pkts));  // [RULE3]

  // Aware mode: per filler octet; agnostic: per filler packet
  assign err = play.valid && play.filler
            && (cfg.structured || play.pkt_end);  // [RULE6] [RULE7]

  // Current second is severe if the threshold is met
  assign sec_ses = sat_add(sec_err_q, 16'(err)) >= cfg.ses_thr;  // [RULE9]

  // Expected sequence; late packets cannot be reordered without a store
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      have_seq_q  <= 1'b0;
      exp_q       <= 16'h0;
      rx_accept_q <= 1'b0;
      rx_drop_q   <= 1'b0;
    end else begin
      rx_accept_q <= is_pw && !late;
      rx_drop_q   <= (rx_valid && !rx_is_pw) || (is_pw && late);  // [RULE15] [RULE20]
      if (is_pw && !late) begin
        have_seq_q <= 1'b1;
        exp_q      <= rx_seq + 16'h1;
      end
    end
  end

  // Lost and unreordered totals; untouched by stray packets
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q.unreord <= 32'h0;
      stat_q.lost    <= 32'h0;
    end else begin
      if (is_pw && late) stat_q.unreord <= stat_q.unreord + 32'h1;  // [RULE15]
      if (lost_stb) stat_q.lost <= stat_q.lost + 32'(gap);          // [RULE21]
    end
  end

  // Loss window restarts every configured number of seconds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_tot_q  <= 16'h0;
      win_lost_q <= 16'h0;
      win_sec_q  <= 8'h0;
    end else if (tick && (win_sec_q + 8'h1 >= cfg.win_secs)) begin
      win_sec_q  <= 8'h0;
      win_tot_q  <= 16'h0;
      win_lost_q <= 16'h0;
    end else begin
      if (tick) win_sec_q <= win_sec_q + 8'h1;
      if (is_pw && !late) begin
        win_tot_q  <= sat_add(win_tot_q, sat_add(gap, 16'h1));
        if (lost_stb) win_lost_q <= sat_add(win_lost_q, gap);
      end
    end
  end

  // Packets played clean in a row since the last filler
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_bad_q <= 1'b0;
      good_q    <= 8'h0;
    end else if (play.valid) begin
      if (play.pkt_end) begin
        pkt_bad_q <= 1'b0;
        if (pkt_bad_q || play.filler) good_q <= 8'h0;
        else if (good_q != 8'hff) good_q <= good_q + 8'h1;
      end else if (play.filler) begin
        pkt_bad_q <= 1'b1;
      end
    end
  end

  // Time in loss, restarted on each entry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) loss_cyc_q <= 32'h0;
    else if (!in_loss) loss_cyc_q <= 32'h0;
    else if (loss_cyc_q != 32'hffffffff) loss_cyc_q <= loss_cyc_q + 32'h1;
  end

  // Quiet time, restarted by any error defect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) quiet_q <= 32'h0;
    else if (err) quiet_q <= 32'h0;
    else if (quiet_q != 32'hffffffff) quiet_q <= quiet_q + 32'h1;
  end

  // Loss state and alarm; the alarm outlives the loss until quiet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_OK;
    end else begin
      unique case (st_q)
        ST_OK: begin
          if (enter) st_q <= ST_LOSS;  // [RULE1]
        end
        ST_LOSS: begin
          if (leave) st_q <= ST_OK;  // [RULE3]
          else if (loss_cyc_q >= LOSS_CYC) st_q <= ST_ALARM;  // [RULE4]
        end
        ST_ALARM: begin
          if (leave) st_q <= ST_HOLD;  // [RULE3]
        end
        ST_HOLD: begin
          if (enter) st_q <= ST_ALARM;
          else if (quiet_q >= CLR_CYC) st_q <= ST_OK;  // [RULE5]
        end
      endcase
    end
  end

  // Registered status toward the packet transmitter and software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_rbit_q    <= 1'b0;
      loss_state_q <= 1'b0;
      loss_alarm_q <= 1'b0;
    end else begin
      tx_rbit_q    <= in_loss;  // [RULE2]
      loss_state_q <= in_loss;
      loss_alarm_q <= (st_q == ST_ALARM) || (st_q == ST_HOLD);  // [RULE4] [RULE5]
    end
  end

  // Defects and loss state seen within the current second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_err_q   <= 16'h0;
      sec_alarm_q <= 1'b0;
    end else if (tick) begin
      sec_err_q   <= 16'h0;  // A defect on the tick falls in the closing second
      sec_alarm_q <= 1'b0;
    end else begin
      sec_err_q <= sat_add(sec_err_q, 16'(err));  // [RULE6]
      if (in_loss) sec_alarm_q <= 1'b1;  // [RULE19]
    end
  end

  // Second classification on each tick; counters belong to this pseudowire
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q.es  <= 32'h0;
      stat_q.ses <= 32'h0;
    end else if (tick) begin
      if (sat_add(sec_err_q, 16'(err)) != 16'h0) stat_q.es <= stat_q.es + 32'h1;  // [RULE8] [RULE11]
      if (sec_ses) stat_q.ses <= stat_q.ses + 32'h1;  // [RULE9] [RULE11]
    end
  end

  // Availability runs: ten severe to enter, ten clean to leave
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ses_run_q <= 4'h0;
      ok_run_q  <= 4'h0;
      unavail_q <= 1'b0;
    end else if (tick) begin
      ses_run_q <= sec_ses ? ((ses_run_q < UAS_RUN) ? ses_run_q + 4'h1 : ses_run_q) : 4'h0;
      ok_run_q  <= sec_ses ? 4'h0 : ((ok_run_q < UAS_RUN) ? ok_run_q + 4'h1 : ok_run_q);
      if (!unavail_q && sec_ses && (ses_run_q + 4'h1 >= UAS_RUN)) unavail_q <= 1'b1;  // [RULE10]
      else if (unavail_q && !sec_ses && (ok_run_q + 4'h1 >= UAS_RUN)) unavail_q <= 1'b0;  // [RULE10]
    end
  end

  // Unavailable seconds, counted from the tenth severe second onward
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) stat_q.uas <= 32'h0;
    else if (tick && (unavail_q || (sec_ses && (ses_run_q + 4'h1 >= UAS_RUN))))
      stat_q.uas <= stat_q.uas + 32'h1;  // [RULE10] [RULE11]
  end

  // Fill octet register, all ones out of reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) fill_q <= FILL_RST;  // [RULE16]
    else if (fill_wr) fill_q <= fill_val;
  end

  // TDM toward the service port; framing octets pass in aware mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdm_valid_q <= 1'b0;
      tdm_data_q  <= ONES;
      tdm_dl_q    <= 1'b1;
    end else begin
      tdm_valid_q <= play.valid;
      if (play.valid) begin
        if (!cfg.pw_up) begin
          tdm_data_q <= ONES;  // [RULE22]
          tdm_dl_q   <= 1'b1;
        end else begin
          if ((play.filler || in_loss) && !(cfg.structured && play.framing))
            tdm_data_q <= fill_q;  // [RULE12] [RULE13] [RULE16]
          else
            tdm_data_q <= play.data;  // [RULE13]
          tdm_dl_q <= (cfg.esf && (in_loss || play.filler)) ? 1'b1 : play.dl;  // [RULE17]
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- pdm_monitor_assertions.sv ----
// Port checker for the pseudowire defect monitor
`timescale 1ns/1ns
`default_nettype none
module pdm_monitor_chk #(
  parameter int unsigned LOSS_CYC = pdm_pkg::LOSS_CYC
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire pdm_pkg::pdm_cfg_type  cfg,
  input wire logic                  rx_valid,
  input wire logic                  rx_is_pw,
  input wire pdm_pkg::pdm_play_type play,
  input wire logic                  rx_accept_q,
  input wire logic                  rx_drop_q,
  input wire logic                  tx_rbit_q,
  input wire logic                  loss_state_q,
  input wire logic                  loss_alarm_q,
  input wire logic                  unavail_q,
  input wire logic                  tdm_valid_q,
  input wire logic [7:0]            tdm_data_q,
  input wire logic                  tdm_dl_q,
  input wire logic [7:0]            fill_q,
  input wire pdm_pkg::pdm_stat_type stat_q
);
  import pdm_pkg::*;
  logic [31:0] run_q;  // Cycles spent in loss so far
  // Loss time, so the alarm moment can be bounded from both sides
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 32'h0;
    end else begin
      run_q <= loss_state_q ? run_q + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_stray_drop: assert property (rx_valid && !rx_is_pw |=> rx_drop_q && !rx_accept_q)
    else $error("stray packet not dropped");
  a_stray_stats: assert property (rx_valid && !rx_is_pw |=> $stable(stat_q.lost))
    else $error("stray packet moved loss count");
  a_pw_answer: assert property (rx_valid && rx_is_pw |=> rx_accept_q ^ rx_drop_q)
    else $error("packet got no single answer");
  a_rbit_loss: assert property (tx_rbit_q == loss_state_q)
    else $error("R bit differs from loss state");
  a_idle_ones: assert property (play.valid && !cfg.pw_up |=>
    tdm_valid_q && tdm_data_q == 8'hff && tdm_dl_q)
    else $error("no all ones outside service");
  a_fill_out: assert property (play.valid && cfg.pw_up && play.filler &&
    !(cfg.structured && play.framing) |=> tdm_data_q == $past(fill_q))
    else $error("filler octet not replaced by fill");
  a_frame_kept: assert property (play.valid && cfg.pw_up && cfg.structured &&
    play.framing |=> tdm_data_q == $past(play.data))
    else $error("framing octet altered");
  a_esf_dl: assert property (play.valid && cfg.pw_up && cfg.esf && play.filler |=> tdm_dl_q)
    else $error("data link bit not one on filler");
  a_alarm_time: assert property ($rose(loss_alarm_q) |->
    run_q + 32'h2 >= LOSS_CYC && run_q <= LOSS_CYC + 2)
    else $error("alarm raised at wrong loss time");
  a_alarm_clear: assert property ($fell(loss_alarm_q) |-> !loss_state_q)
    else $error("alarm cleared while in loss");
  c_alarm: cover property ($rose(loss_alarm_q));
  c_unavail: cover property ($rose(unavail_q));
  c_drop: cover property (rx_drop_q);
endmodule
bind pdm_monitor pdm_monitor_chk #(.LOSS_CYC(LOSS_CYC)) u_chk (.clk, .rst_n, .cfg, .rx_valid,
  .rx_is_pw, .play, .rx_accept_q, .rx_drop_q, .tx_rbit_q, .loss_state_q, .loss_alarm_q,
  .unavail_q, .tdm_valid_q, .tdm_data_q, .tdm_dl_q, .fill_q, .stat_q);
`default_nettype wire

// ---- pdm_monitor_test.sv ----
// Self-checking bench for the pseudowire defect monitor
`timescale 1ns/1ns
`default_nettype none
module pdm_monitor_test;
  import pdm_pkg::*;
  logic clk, rst_n, fill_wr, rx_valid, rx_is_pw, rx_accept_q, rx_drop_q, tx_rbit_q;
  logic loss_state_q, loss_alarm_q, unavail_q, tdm_valid_q, tdm_dl_q;
  logic [7:0] fill_val, tdm_data_q, fill_q;
  logic [15:0] rx_seq;
  logic [6:0] hist_idx, hist_ptr_q, p0;
  logic [31:0] e0, s0, u0;
  pdm_cfg_type cfg;
  pdm_play_type play;
  pdm_stat_type stat_q;
  pdm_hist_type cur_intv_q, hist_q;
  int err_count = 0;
  int comparisons = 0;
  // Short counts so seconds last 20 cycles
  pdm_monitor #(.TICK_CYC(20), .LOSS_CYC(50), .CLR_CYC(200), .INTV_SECS(4)) u_dut (
    .clk, .rst_n, .cfg, .fill_wr, .fill_val, .rx_valid, .rx_is_pw, .rx_seq, .play,
    .hist_idx, .rx_accept_q, .rx_drop_q, .tx_rbit_q, .loss_state_q, .loss_alarm_q,
    .unavail_q, .tdm_valid_q, .tdm_data_q, .tdm_dl_q, .fill_q, .stat_q, .cur_intv_q,
    .hist_q, .hist_ptr_q);
  pdm_peer u_peer (.clk, .rx_valid, .rx_is_pw, .rx_seq, .play);
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk_bit(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait for the alarm level; running out is a mismatch
  task automatic wait_alarm(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && loss_alarm_q !== v; i++) @(negedge clk);
    if (loss_alarm_q !== v) begin
      chk_bit("alarm wait", v, loss_alarm_q);
      stop_test();
    end
  endtask
  initial begin
    rst_n = 1'b0;
    cfg = '0;
    cfg.loss_pct = 7'd100;
    cfg.win_secs = 8'h01;
    cfg.ses_thr = 16'hffff;
    fill_wr = 1'b0;
    fill_val = 8'h00;
    hist_idx = 7'h00;
    cyc(10);
    rst_n = 1'b1;
    chk_val("fill reset", 32'hff, {24'h0, fill_q});
    u_peer.oct(4'h0, 8'h3c);
    chk_val("idle data", 32'hff, {24'h0, tdm_data_q});
    chk_bit("idle dl", 1'b1, tdm_dl_q);
    cfg.pw_up = 1'b1;
    cfg.miss_run = 8'h04;
    cfg.good_run = 8'h03;
    fill_val = 8'h7e;
    fill_wr = 1'b1;
    cyc(1);
    fill_wr = 1'b0;
    cyc(1);
    chk_val("fill load", 32'h7e, {24'h0, fill_q});
    u_peer.pkt(1'b1, 16'h0010);
    u_peer.pkt(1'b1, 16'h0013);
    chk_val("lost", 32'h2, stat_q.lost);
    chk_val("intv lost", 32'h2, cur_intv_q.lost);
    chk_bit("loss short gap", 1'b0, loss_state_q);
    u_peer.pkt(1'b0, 16'h0040);
    chk_val("lost stray", 32'h2, stat_q.lost);
    u_peer.pkt(1'b1, 16'h0012);
    chk_val("unreord", 32'h1, stat_q.unreord);
    u_peer.pkt(1'b1, 16'h0018);
    chk_bit("loss run", 1'b1, loss_state_q);
    chk_bit("rbit", 1'b1, tx_rbit_q);
    chk_val("lost run", 32'h6, stat_q.lost);
    chk_bit("alarm early", 1'b0, loss_alarm_q);
    cfg.structured = 1'b1;
    cfg.esf = 1'b1;
    // A filler packet in loss restarts the quiet time before the alarm clears
    u_peer.oct(4'ha, 8'h55);
    chk_val("loss fill", 32'h7e, {24'h0, tdm_data_q});
    chk_bit("loss dl", 1'b1, tdm_dl_q);
    u_peer.oct(4'h4, 8'h1b);
    chk_val("framing", 32'h1b, {24'h0, tdm_data_q});
    wait_alarm(1'b1, 60);
    for (int k = 0; k < 3; k++) u_peer.oct(4'h2, 8'h55);
    // Octets of the clean run still play filled; the next one passes
    u_peer.oct(4'h0, 8'h55);
    chk_bit("loss exit", 1'b0, loss_state_q);
    chk_val("clean data", 32'h55, {24'h0, tdm_data_q});
    cyc(100);
    chk_bit("alarm held", 1'b1, loss_alarm_q);
    wait_alarm(1'b0, 130);
    // Agnostic: three filler octets form one filler packet
    cfg.structured = 1'b0;
    cfg.ses_thr = 16'h0002;
    e0 = stat_q.es;
    s0 = stat_q.ses;
    u_peer.oct(4'h8, 8'h11);
    chk_val("filler fill", 32'h7e, {24'h0, tdm_data_q});
    u_peer.oct(4'h8, 8'h11);
    u_peer.oct(4'ha, 8'h11);
    cyc(40);
    chk_val("es", e0 + 32'h1, stat_q.es);
    chk_val("ses light", s0, stat_q.ses);
    // Every second severe from here; sync on the first one counted
    u0 = stat_q.uas;
    s0 = stat_q.ses;
    cfg.ses_thr = 16'h0000;
    for (int k = 0; k < 30 && stat_q.ses === s0; k++) @(negedge clk);
    chk_val("ses sync", s0 + 32'h1, stat_q.ses);
    cyc(170);
    chk_bit("avail nine", 1'b0, unavail_q);
    cyc(20);
    chk_bit("unavail", 1'b1, unavail_q);
    chk_val("ses ten", s0 + 32'ha, stat_q.ses);
    chk_val("uas", u0 + 32'h1, stat_q.uas);
    cfg.ses_thr = 16'hffff;
    cyc(180);
    chk_bit("unavail held", 1'b1, unavail_q);
    cyc(20);
    chk_bit("avail again", 1'b0, unavail_q);
    p0 = hist_ptr_q;
    cyc(160);
    chk_val("hist ptr", {25'h0, p0 + 7'h2}, {25'h0, hist_ptr_q});
    chk_val("hist lost", 32'h6, hist_q.lost);
    chk_bit("hist alarm", 1'b1, hist_q.alarm_secs != 16'h0);
    stop_test();
  end
endmodule
`default_nettype wire

// ---- pdm_peer.sv ----
// Peer unit and jitter buffer model driving the packet and playout side
`timescale 1ns/1ns
`default_nettype none
module pdm_peer (
  input  wire logic             clk,
  output logic                  rx_valid,
  output logic                  rx_is_pw,
  output logic [15:0]           rx_seq,
  output pdm_pkg::pdm_play_type play
);
  import pdm_pkg::*;
  // Idle lines start quiet
  initial begin
    rx_valid = 1'b0;
    rx_is_pw = 1'b0;
    rx_seq   = 16'h0000;
    play     = '0;
  end
  // One header for one edge; the sequence is scrambled once released
  task automatic pkt(input logic pw, input logic [15:0] seq);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_is_pw = pw;
    rx_seq   = seq;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_seq   = ~seq;
    @(negedge clk);
  endtask
  // One octet out of the buffer; f is filler, framing, end, data link
  task automatic oct(input logic [3:0] f, input logic [7:0] d);
    @(negedge clk);
    play = {1'b1, f, d};
    @(negedge clk);
    play = {1'b0, ~f, ~d};
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ---- pdm_pkg.sv ----
// Constants, types and defect rules of the pseudowire defect monitor
// Function
// [RULE1] Enter loss state on loss percentage or run
// [RULE2] Set R bit while in loss state
// [RULE3] Leave loss on good run or buffer
// [RULE4] Raise loss alarm after 2.5 s loss
// [RULE5] Clear loss alarm after 10 quiet seconds
// [RULE6] Each filler play-out is one error defect
// [RULE7] Agnostic mode: one defect per filler packet
// [RULE8] Count seconds holding any error defect
// [RULE9] Count seconds at or over threshold
// [RULE10] Unavailable after ten severe, until ten clean
// [RULE11] Separate second counters per pseudowire
// [RULE12] Fill TDM output during loss or gaps
// [RULE13] Aware mode fills timeslots, keeps framing
// [RULE14] Detect out-of-sequence packets
// [RULE15] Drop and count unreordered packets
// [RULE16] Fill octet configurable, resets to ones
// [RULE17] ESF data link bits one during loss
// [RULE18] Keep 96 fifteen-minute loss intervals
// [RULE19] Per interval: lost packets, alarm seconds; counted here as seconds in loss state
// [RULE20] Drop packets not of a pseudowire
// [RULE21] Stray drops leave loss statistics alone
// [RULE22] All ones to service port outside service
// [RULE23] Derive one-second tick from clock
package pdm_pkg;
  localparam int unsigned CLK_HZ     = 50_000_000;   // Device clock rate
  localparam int unsigned LOSS_MS    = 2500;         // Loss time before alarm
  localparam int unsigned CLR_MS     = 10000;        // Quiet time to clear alarm
  localparam int unsigned TICK_CYC   = CLK_HZ;       // Cycles per second
  localparam int unsigned LOSS_CYC   = CLK_HZ / 1000 * LOSS_MS;
  localparam int unsigned CLR_CYC    = CLK_HZ / 1000 * CLR_MS;
  localparam int unsigned INTV_SECS  = 900;          // Seconds per interval
  localparam int unsigned HIST_DEPTH = 96;           // Intervals kept
  localparam logic [3:0]  UAS_RUN    = 4'ha;         // Seconds to change state
  localparam logic [7:0]  FILL_RST   = 8'hff;        // Fill octet after reset
  localparam logic [7:0]  ONES       = 8'hff;        // Idle pattern

  // Loss state machine, Gray along ok-loss-alarm-hold
  typedef enum logic [1:0] {
    ST_OK    = 2'b00,
    ST_LOSS  = 2'b01,
    ST_ALARM = 2'b11,
    ST_HOLD  = 2'b10
  } pdm_state_type;

  // Static configuration of one pseudowire
  typedef struct packed {
    logic        pw_up;       // Set up and able to retransmit
    logic        structured;  // Structure-aware mode
    logic        esf;         // T1 extended superframe
    logic [6:0]  loss_pct;    // Loss percentage to enter
    logic [7:0]  win_secs;    // Loss window in seconds
    logic [7:0]  miss_run;    // Consecutive missing to enter
    logic [7:0]  good_run;    // Clean packets to leave
    logic [7:0]  jb_pkts;     // Jitter buffer depth in packets
    logic [15:0] ses_thr;     // Severe second threshold
  } pdm_cfg_type;

  // One octet leaving the jitter buffer
  typedef struct packed {
    logic       valid;
    logic       filler;       // Octet is filler, not received data
    logic       framing;      // Octet carries transport framing
    logic       pkt_end;      // Last octet of a packet
    logic       dl;           // Data link bit of this octet
    logic [7:0] data;
  } pdm_play_type;

  // Performance counters
  typedef struct packed {
    logic [31:0] es;
    logic [31:0] ses;
    logic [31:0] uas;
    logic [31:0] unreord;
    logic [31:0] lost;
  } pdm_stat_type;

  // One fifteen-minute record
  typedef struct packed {
    logic [31:0] lost;
    logic [15:0] alarm_secs;
  } pdm_hist_type;
endpackage

// ---- pdm_tick.sv ----
// One-second timebase divider
`timescale 1ns/1ns
`default_nettype none
module pdm_tick #(
  parameter int unsigned TICK_CYC = pdm_pkg::TICK_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick_q
);
  import pdm_pkg::*;

  logic [31:0] cnt_q;  // Cycles into the current second

  // Free-running divider, one-cycle pulse each second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 32'h0;
      tick_q <= 1'b0;
    end else if (cnt_q >= TICK_CYC - 1) begin
      cnt_q  <= 32'h0;  // [RULE23]
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 32'h1;
      tick_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire
